// ---- verilog/wad_pkg.sv ----
// constants, field layouts and carrier types of the wire adapter descriptor store
package wad_pkg;

    // ------------------------------------------------------------
    // companion descriptor (isochronous streaming in endpoint)
    // ------------------------------------------------------------
    localparam logic [4:0]  WAD_COMP_LEN_BYTES      = 5'h0a;
    localparam logic [7:0]  WAD_COMP_LENGTH         = 8'h0a;
    localparam logic [7:0]  WAD_COMP_TYPE           = 8'h11;
    localparam logic [7:0]  WAD_COMP_MAX_BURST      = 8'h01;
    localparam logic [7:0]  WAD_COMP_MAX_SEQ        = 8'h10;
    localparam logic [7:0]  WAD_COMP_MAX_SEQ_MIN    = 8'h02;
    localparam logic [7:0]  WAD_COMP_MAX_SEQ_MAX    = 8'h20;
    localparam logic [15:0] WAD_COMP_STREAM_DELAY   = 16'h0010;
    localparam logic [15:0] WAD_COMP_RADIO_PKT      = 16'h0400;
    localparam logic [7:0]  WAD_COMP_RADIO_INTERVAL = 8'h00;
    localparam logic [7:0]  WAD_COMP_ATTRIBUTES     = 8'h02;

    localparam logic [4:0]  WAD_COFF_LENGTH   = 5'h00;
    localparam logic [4:0]  WAD_COFF_TYPE     = 5'h01;
    localparam logic [4:0]  WAD_COFF_BURST    = 5'h02;
    localparam logic [4:0]  WAD_COFF_SEQ      = 5'h03;
    localparam logic [4:0]  WAD_COFF_DELAY_LO = 5'h04;
    localparam logic [4:0]  WAD_COFF_DELAY_HI = 5'h05;
    localparam logic [4:0]  WAD_COFF_PKT_LO   = 5'h06;
    localparam logic [4:0]  WAD_COFF_PKT_HI   = 5'h07;
    localparam logic [4:0]  WAD_COFF_INTERVAL = 5'h08;
    localparam logic [4:0]  WAD_COFF_ATTR     = 5'h09;

    // ------------------------------------------------------------
    // remote pipe descriptor
    // ------------------------------------------------------------
    localparam logic [4:0]  WAD_PIPE_LEN_BYTES  = 5'h1c;
    localparam logic [7:0]  WAD_PIPE_LENGTH     = 8'h1c;
    localparam logic [7:0]  WAD_PIPE_TYPE       = 8'h22;
    localparam logic [15:0] WAD_PIPE_INDEX      = 16'h0000;
    localparam logic [15:0] WAD_PIPE_REQ_COUNT  = 16'h0004;

    localparam logic [4:0]  WAD_POFF_LENGTH   = 5'h00;
    localparam logic [4:0]  WAD_POFF_TYPE     = 5'h01;
    localparam logic [4:0]  WAD_POFF_INDEX_LO = 5'h02;
    localparam logic [4:0]  WAD_POFF_INDEX_HI = 5'h03;
    localparam logic [4:0]  WAD_POFF_REQ_LO   = 5'h04;
    localparam logic [4:0]  WAD_POFF_REQ_HI   = 5'h05;
    localparam logic [4:0]  WAD_POFF_BLK_LO   = 5'h06;
    localparam logic [4:0]  WAD_POFF_BLK_HI   = 5'h07;
    localparam logic [4:0]  WAD_POFF_MPS_LO   = 5'h08;
    localparam logic [4:0]  WAD_POFF_MPS_HI   = 5'h09;
    localparam logic [4:0]  WAD_POFF_HUB_ADDR = 5'h0a;
    localparam logic [4:0]  WAD_POFF_HUB_PORT = 5'h0b;
    localparam logic [4:0]  WAD_POFF_SPEED    = 5'h0c;

    // writable byte slots held in the byte register array
    localparam int WAD_NSLOT      = 7;
    localparam int WAD_SLOT_BLKLO = 0;
    localparam int WAD_SLOT_BLKHI = 1;
    localparam int WAD_SLOT_MPSLO = 2;
    localparam int WAD_SLOT_MPSHI = 3;
    localparam int WAD_SLOT_HUBA  = 4;
    localparam int WAD_SLOT_HUBP  = 5;
    localparam int WAD_SLOT_SPEED = 6;
    localparam logic [7:0] WAD_SLOT_RST = 8'h00;

    typedef enum logic [1:0] {
        WAD_SPEED_FULL = 2'b00,
        WAD_SPEED_LOW  = 2'b01,
        WAD_SPEED_HIGH = 2'b10,
        WAD_SPEED_RSVD = 2'b11
    } wad_speed_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       pipe_sel;
        logic [4:0] offset;
        logic [7:0] wdata;
    } wad_req_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] rdata;
    } wad_rsp_t;

    typedef struct packed {
        logic [15:0] buffer_blocks;
        logic [15:0] max_packet;
        logic [7:0]  hub_address;
        logic [7:0]  hub_port;
        logic [7:0]  speed;
    } wad_pipe_cfg_t;

endpackage : wad_pkg

// ---- verilog/wad_byte_reg.sv ----
// one writable byte of descriptor storage with a fixed reset value
`timescale 1ns/100ps
module wad_byte_reg
    import wad_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] q
);

    logic [7:0] q_r;
    logic [7:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (wr_en) begin
            q_nxt = wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule : wad_byte_reg

// ---- verilog/wad_desc_store.sv ----
// descriptor store: streaming in companion descriptor and one remote pipe descriptor
//
// Function
// - companion descriptor reads length ten and wireless companion type seventeen
// - companion maximum burst sequence reads only values from two to thirty-two
// - companion radio packet size gives largest in packet sent over radio
// - companion radio poll interval reads zero: all intervals four to 255 accepted
// - companion attributes read 02h: continuously scalable dynamic switching supported
// - device reports only maximum stream delay; host driver picks actual delay
// - pipe descriptor is fetched alone by its own get request
// - pipe descriptor length reads 1ch and is read only
// - pipe descriptor type reads 22h and cannot be changed
// - pipe index is a read-only zero-based slot number
// - request count is read only: concurrent requests for this pipe
// - buffer block count may be set by host while it reads zero
// - nonzero buffer block count stays fixed; host writes ignored
// - pipe max packet size gives largest packet toward downstream device
// - speed code 00b selects full speed, twelve megabits
// - speed 01b low, 10b high; 11b reserved, never stored
`timescale 1ns/100ps
module wad_desc_store
    import wad_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    reset_n,
    input  wire wad_req_t req,
    output wad_rsp_t      rsp,
    output wad_pipe_cfg_t pipe_cfg
);

    // ------------------------------------------------------------
    // writable byte slots
    // ------------------------------------------------------------
    logic [7:0] slot_q   [WAD_NSLOT];
    logic [7:0] slot_wd  [WAD_NSLOT];
    logic       slot_we  [WAD_NSLOT];

    genvar gi;
    generate
        for (gi = 0; gi < WAD_NSLOT; gi++) begin : g_slot
            wad_byte_reg #(
                .RST_VAL (WAD_SLOT_RST)
            ) u_slot (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .wr_en    (slot_we[gi]),
                .wr_data  (slot_wd[gi]),
                .q        (slot_q[gi])
            );
        end
    endgenerate

    logic [15:0] blocks;
    logic [15:0] max_packet;
    assign blocks     = {slot_q[WAD_SLOT_BLKHI], slot_q[WAD_SLOT_BLKLO]};
    assign max_packet = {slot_q[WAD_SLOT_MPSHI], slot_q[WAD_SLOT_MPSLO]};

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // the low byte of the block count is staged so the lock is judged once,
    // on the high byte; a byte-wise commit would lock after the first byte
    logic [7:0] blk_stage_r;
    logic [7:0] blk_stage_nxt;
    logic       wr_ignored;
    logic       pipe_wr;

    assign pipe_wr = req.valid && req.write && req.pipe_sel;

    always_comb begin
        blk_stage_nxt = blk_stage_r;
        wr_ignored    = 1'b0;
        for (int i = 0; i < WAD_NSLOT; i++) begin
            slot_we[i] = 1'b0;
            slot_wd[i] = req.wdata;
        end
        if (req.valid && req.write && !req.pipe_sel) begin
            wr_ignored = 1'b1;
        end else if (pipe_wr) begin
            unique case (req.offset)
                WAD_POFF_BLK_LO: begin
                    if (blocks == 16'h0000) begin
                        blk_stage_nxt = req.wdata;
                    end else begin
                        wr_ignored = 1'b1;
                    end
                end
                WAD_POFF_BLK_HI: begin
                    if (blocks == 16'h0000) begin
                        slot_we[WAD_SLOT_BLKLO] = 1'b1;
                        slot_wd[WAD_SLOT_BLKLO] = blk_stage_r;
                        slot_we[WAD_SLOT_BLKHI] = 1'b1;
                    end else begin
                        wr_ignored = 1'b1;
                    end
                end
                WAD_POFF_MPS_LO:   slot_we[WAD_SLOT_MPSLO] = 1'b1;
                WAD_POFF_MPS_HI:   slot_we[WAD_SLOT_MPSHI] = 1'b1;
                WAD_POFF_HUB_ADDR: slot_we[WAD_SLOT_HUBA]  = 1'b1;
                WAD_POFF_HUB_PORT: slot_we[WAD_SLOT_HUBP]  = 1'b1;
                WAD_POFF_SPEED: begin
                    // only full, low and high codes are stored
                    if (req.wdata <= {6'h00, WAD_SPEED_HIGH}) begin
                        slot_we[WAD_SLOT_SPEED] = 1'b1;
                    end else begin
                        wr_ignored = 1'b1;
                    end
                end
                default: wr_ignored = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blk_stage_r <= 8'h00;
        end else begin
            blk_stage_r <= blk_stage_nxt;
        end
    end

    // ------------------------------------------------------------
    // read mux, little endian
    // ------------------------------------------------------------
    logic [7:0] comp_byte;
    logic [7:0] pipe_byte;

    always_comb begin
        unique case (req.offset)
            WAD_COFF_LENGTH:   comp_byte = WAD_COMP_LENGTH;
            WAD_COFF_TYPE:     comp_byte = WAD_COMP_TYPE;
            WAD_COFF_BURST:    comp_byte = WAD_COMP_MAX_BURST;
            WAD_COFF_SEQ:      comp_byte = WAD_COMP_MAX_SEQ;
            WAD_COFF_DELAY_LO: comp_byte = WAD_COMP_STREAM_DELAY[7:0];
            WAD_COFF_DELAY_HI: comp_byte = WAD_COMP_STREAM_DELAY[15:8];
            WAD_COFF_PKT_LO:   comp_byte = WAD_COMP_RADIO_PKT[7:0];
            WAD_COFF_PKT_HI:   comp_byte = WAD_COMP_RADIO_PKT[15:8];
            WAD_COFF_INTERVAL: comp_byte = WAD_COMP_RADIO_INTERVAL;
            WAD_COFF_ATTR:     comp_byte = WAD_COMP_ATTRIBUTES;
            default:           comp_byte = 8'h00;
        endcase
    end

    always_comb begin
        unique case (req.offset)
            WAD_POFF_LENGTH:   pipe_byte = WAD_PIPE_LENGTH;
            WAD_POFF_TYPE:     pipe_byte = WAD_PIPE_TYPE;
            WAD_POFF_INDEX_LO: pipe_byte = WAD_PIPE_INDEX[7:0];
            WAD_POFF_INDEX_HI: pipe_byte = WAD_PIPE_INDEX[15:8];
            WAD_POFF_REQ_LO:   pipe_byte = WAD_PIPE_REQ_COUNT[7:0];
            WAD_POFF_REQ_HI:   pipe_byte = WAD_PIPE_REQ_COUNT[15:8];
            WAD_POFF_BLK_LO:   pipe_byte = blocks[7:0];
            WAD_POFF_BLK_HI:   pipe_byte = blocks[15:8];
            WAD_POFF_MPS_LO:   pipe_byte = max_packet[7:0];
            WAD_POFF_MPS_HI:   pipe_byte = max_packet[15:8];
            WAD_POFF_HUB_ADDR: pipe_byte = slot_q[WAD_SLOT_HUBA];
            WAD_POFF_HUB_PORT: pipe_byte = slot_q[WAD_SLOT_HUBP];
            WAD_POFF_SPEED:    pipe_byte = slot_q[WAD_SLOT_SPEED];
            // fields beyond speed belong to logic outside this store
            default:           pipe_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // answer register
    // ------------------------------------------------------------
    // each descriptor is its own selection; the pipe descriptor never
    // rides along with the companion bytes
    wad_rsp_t rsp_r;
    wad_rsp_t rsp_nxt;

    always_comb begin
        rsp_nxt = '0;
        if (req.valid) begin
            rsp_nxt.valid = 1'b1;
            if (req.pipe_sel) begin
                if (req.offset >= WAD_PIPE_LEN_BYTES) begin
                    rsp_nxt.err = 1'b1;
                end else begin
                    rsp_nxt.rdata = pipe_byte;
                    rsp_nxt.err   = wr_ignored;
                end
            end else begin
                if (req.offset >= WAD_COMP_LEN_BYTES) begin
                    rsp_nxt.err = 1'b1;
                end else begin
                    rsp_nxt.rdata = comp_byte;
                    rsp_nxt.err   = wr_ignored;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign rsp = rsp_r;

    assign pipe_cfg.buffer_blocks = blocks;
    assign pipe_cfg.max_packet    = max_packet;
    assign pipe_cfg.hub_address   = slot_q[WAD_SLOT_HUBA];
    assign pipe_cfg.hub_port      = slot_q[WAD_SLOT_HUBP];
    assign pipe_cfg.speed         = slot_q[WAD_SLOT_SPEED];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic comp_rd;
    logic pipe_rd;
    assign comp_rd = req.valid && !req.write && !req.pipe_sel;
    assign pipe_rd = req.valid && !req.write && req.pipe_sel;

    property p_comp_head;
        comp_rd && req.offset == WAD_COFF_TYPE |=> rsp.valid && rsp.rdata == 8'h11;
    endproperty
    a_comp_head: assert property (p_comp_head) else $error("companion type wrong");

    property p_seq_range;
        comp_rd && req.offset == WAD_COFF_SEQ
            |=> rsp.rdata >= 8'h02 && rsp.rdata <= 8'h20;
    endproperty
    a_seq_range: assert property (p_seq_range) else $error("max sequence illegal");

    property p_comp_tail;
        comp_rd && req.offset == WAD_COFF_ATTR |=> rsp.rdata == 8'h02 && !rsp.err;
    endproperty
    a_comp_tail: assert property (p_comp_tail) else $error("attributes wrong");

    property p_pipe_len;
        pipe_rd && req.offset == WAD_POFF_LENGTH |=> rsp.rdata == 8'h1c;
    endproperty
    a_pipe_len: assert property (p_pipe_len) else $error("pipe length wrong");

    property p_blk_lock;
        blocks != 16'h0000 |=> blocks == $past(blocks);
    endproperty
    a_blk_lock: assert property (p_blk_lock) else $error("locked blocks changed");

    property p_blk_set;
        pipe_wr && req.offset == WAD_POFF_BLK_HI && blocks == 16'h0000
            |=> blocks == {$past(req.wdata), $past(blk_stage_r)} && !rsp.err;
    endproperty
    a_blk_set: assert property (p_blk_set) else $error("block count not taken");

    property p_speed_legal;
        pipe_cfg.speed[1:0] != 2'b11 && pipe_cfg.speed[7:2] == 6'h00;
    endproperty
    a_speed_legal: assert property (p_speed_legal) else $error("reserved speed stored");

    property p_comp_len;
        comp_rd && req.offset == WAD_COFF_LENGTH
            |=> rsp.valid && rsp.rdata == 8'h0a && !rsp.err;
    endproperty
    a_comp_len: assert property (p_comp_len) else $error("companion length wrong");

    property p_comp_interval;
        comp_rd && req.offset == WAD_COFF_INTERVAL
            |=> rsp.valid && rsp.rdata == 8'h00 && !rsp.err;
    endproperty
    a_comp_interval: assert property (p_comp_interval) else $error("interval not zero");

    property p_radio_pkt;
        comp_rd && req.offset == WAD_COFF_PKT_HI
            |=> rsp.valid && rsp.rdata == WAD_COMP_RADIO_PKT[15:8] && !rsp.err;
    endproperty
    a_radio_pkt: assert property (p_radio_pkt) else $error("radio packet size wrong");

    property p_pipe_type;
        pipe_rd && req.offset == WAD_POFF_TYPE
            |=> rsp.valid && rsp.rdata == 8'h22 && !rsp.err;
    endproperty
    a_pipe_type: assert property (p_pipe_type) else $error("pipe type wrong");

    property p_pipe_index;
        pipe_rd && req.offset == WAD_POFF_INDEX_HI
            |=> rsp.valid && rsp.rdata == WAD_PIPE_INDEX[15:8] && !rsp.err;
    endproperty
    a_pipe_index: assert property (p_pipe_index) else $error("pipe index wrong");

    property p_req_count;
        pipe_rd && req.offset == WAD_POFF_REQ_LO
            |=> rsp.valid && rsp.rdata == WAD_PIPE_REQ_COUNT[7:0] && !rsp.err;
    endproperty
    a_req_count: assert property (p_req_count) else $error("request count wrong");

    property p_mps_write;
        pipe_wr && req.offset == WAD_POFF_MPS_HI
            |=> pipe_cfg.max_packet[15:8] == $past(req.wdata) && !rsp.err;
    endproperty
    a_mps_write: assert property (p_mps_write) else $error("max packet not taken");

    property p_hub_write;
        pipe_wr && req.offset == WAD_POFF_HUB_ADDR
            |=> pipe_cfg.hub_address == $past(req.wdata) && !rsp.err;
    endproperty
    a_hub_write: assert property (p_hub_write) else $error("hub address not taken");

    property p_speed_take;
        pipe_wr && req.offset == WAD_POFF_SPEED && req.wdata <= 8'h02
            |=> pipe_cfg.speed == $past(req.wdata) && !rsp.err;
    endproperty
    a_speed_take: assert property (p_speed_take) else $error("legal speed not taken");

    property p_ro_ignored;
        pipe_wr && req.offset <= WAD_POFF_REQ_HI
            |=> rsp.valid && rsp.err && blocks == $past(blocks);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write taken");

    property p_le_order;
        pipe_rd && req.offset == WAD_POFF_MPS_LO |=> rsp.rdata == $past(max_packet[7:0]);
    endproperty
    a_le_order: assert property (p_le_order) else $error("byte order wrong");

endmodule : wad_desc_store

// ---- tb/wad_host_model.sv ----
// host software model issuing get and set descriptor byte accesses
`timescale 1ns/100ps
module wad_host_model
    import wad_pkg::*;
(
    input  wire logic     core_clk,
    input  wire wad_rsp_t rsp,
    output wad_req_t      req
);
    initial req = '0;

    // ------------------------------------------------------------
    // accesses
    // ------------------------------------------------------------
    // request stands until the taking edge; the answer is read just after it
    task automatic access(input logic wr, input logic sel, input logic [4:0] off,
                          input logic [7:0] wd, output wad_rsp_t ans);
        req.valid    = 1'b1;
        req.write    = wr;
        req.pipe_sel = sel;
        req.offset   = off;
        req.wdata    = wd;
        @(posedge core_clk);
        #1;
        ans = rsp;
    endtask : access

    // released bus: qualifiers scrambled so a stale value never matches
    task automatic idle();
        req.valid  = 1'b0;
        req.offset = ~req.offset;
        req.wdata  = ~req.wdata;
        @(posedge core_clk);
        #1;
    endtask : idle
endmodule : wad_host_model

// ---- tb/wad_desc_store_bench.sv ----
// self-checking bench of the descriptor store
`timescale 1ns/100ps
module wad_desc_store_bench
    import wad_pkg::*;
();
    logic          core_clk;
    logic          reset_n;
    wad_req_t      req;
    wad_rsp_t      rsp;
    wad_pipe_cfg_t pipe_cfg;
    int            errors;
    int            tests_run;
    logic [31:0]   seed;
    logic [31:0]   r;
    logic [15:0]   s_blk;
    logic [15:0]   s_mps;
    logic [7:0]    s_hua;
    logic [7:0]    s_hup;
    logic [7:0]    s_spd;
    logic [7:0]    s_stg;
    wad_rsp_t      a;

    wad_desc_store wad_desc_store_inst (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .req      (req),
        .rsp      (rsp),
        .pipe_cfg (pipe_cfg)
    );
    wad_host_model wad_host_model_inst (
        .core_clk (core_clk),
        .rsp      (rsp),
        .req      (req)
    );

    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // {err, rdata}; 16-bit fields packed so the low byte sits at the lower offset
    function automatic logic [8:0] exp_rd(input logic sel, input logic [4:0] off);
        logic [79:0]  c;
        logic [103:0] p;
        c = {8'h02, 8'h00, WAD_COMP_RADIO_PKT, WAD_COMP_STREAM_DELAY,
             WAD_COMP_MAX_SEQ, WAD_COMP_MAX_BURST, 8'h11, 8'h0a};
        p = {s_spd, s_hup, s_hua, s_mps, s_blk, WAD_PIPE_REQ_COUNT,
             WAD_PIPE_INDEX, 8'h22, 8'h1c};
        if (!sel) return (off < 5'd10) ? {1'b0, c[8*off +: 8]} : 9'h100;
        if (off < 5'd13) return {1'b0, p[8*off +: 8]};
        return (off < 5'd28) ? 9'h000 : 9'h100;
    endfunction : exp_rd

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chk_cfg();
        chk("pipe_cfg", {8'h00, s_blk, s_mps, s_hua, s_hup, s_spd}, {8'h00, pipe_cfg});
    endtask : chk_cfg

    task automatic rd(input logic sel, input logic [4:0] off);
        wad_host_model_inst.access(1'b0, sel, off, 8'h00, a);
        chk("read", {1'b1, exp_rd(sel, off)}, {a.valid, a.err, a.rdata});
    endtask : rd

    task automatic wr(input logic sel, input logic [4:0] off, input logic [7:0] wd);
        logic e;
        e = 1'b1;
        if (sel) begin
            case (off)
                5'h06: if (s_blk == 16'h0) begin s_stg = wd; e = 1'b0; end
                5'h07: if (s_blk == 16'h0) begin s_blk = {wd, s_stg}; e = 1'b0; end
                5'h08: begin s_mps[7:0] = wd; e = 1'b0; end
                5'h09: begin s_mps[15:8] = wd; e = 1'b0; end
                5'h0a: begin s_hua = wd; e = 1'b0; end
                5'h0b: begin s_hup = wd; e = 1'b0; end
                5'h0c: if (wd <= 8'h02) begin s_spd = wd; e = 1'b0; end
                default: ;
            endcase
        end
        wad_host_model_inst.access(1'b1, sel, off, wd, a);
        chk("write", {1'b1, e}, {a.valid, a.err});
    endtask : wr

    task automatic do_reset();
        reset_n = 1'b0;
        {s_blk, s_mps, s_hua, s_hup, s_spd, s_stg} = '0;
        #1;
        chk("reset rsp", '0, rsp);
        repeat (10) @(posedge core_clk);
        chk_cfg();
        #1;
        reset_n = 1'b1;
    endtask : do_reset

    task automatic test_done();
        $display("counts: tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // watchdog well beyond the roughly five hundred cycles the tests take
    initial begin
        #800000;
        errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        errors    = 0;
        tests_run = 0;
        seed      = 32'hbf88;
        do_reset();
        for (int k = 0; k < 11; k++) rd(1'b0, 5'(k));
        wad_host_model_inst.access(1'b0, 1'b0, 5'h03, 8'h00, a);
        chk("max_seq range", 1, a.rdata >= 8'h02 && a.rdata <= 8'h20);
        for (int k = 0; k < 10; k++) wr(1'b0, 5'(k), 8'(rnd()));
        $display("test companion done");
        for (int k = 0; k < 6; k++) begin
            wr(1'b1, 5'(k), 8'(rnd()));
            rd(1'b1, 5'(k));
        end
        rd(1'b1, 5'h0d);
        rd(1'b1, 5'h1b);
        rd(1'b1, 5'h1c);
        rd(1'b1, 5'h1f);
        $display("test pipe read only done");
        // a commit of zero leaves the count open for a later real commit
        wr(1'b1, 5'h07, 8'h00);
        wr(1'b1, 5'h06, 8'(rnd()));
        wr(1'b1, 5'h07, 8'(rnd()) | 8'h01);
        chk_cfg();
        wr(1'b1, 5'h06, 8'h00);
        wr(1'b1, 5'h07, 8'h00);
        rd(1'b1, 5'h06);
        rd(1'b1, 5'h07);
        chk_cfg();
        $display("test buffer blocks done");
        for (int s = 3; s >= 0; s--) begin
            wr(1'b1, 5'h0c, 8'(s));
            rd(1'b1, 5'h0c);
            chk_cfg();
        end
        $display("test speed codes done");
        repeat (300) begin
            r = rnd();
            wr(1'b1, 5'(8 + r % 5), r[15:8]);
            if (r[16]) rd(1'b1, 5'(6 + r[19:17]));
            chk_cfg();
        end
        // directly attached target: host loads zero into both hub fields
        wr(1'b1, 5'h0a, 8'h00);
        wr(1'b1, 5'h0b, 8'h00);
        chk_cfg();
        wad_host_model_inst.idle();
        chk("rsp pulse", 0, rsp.valid);
        $display("test random traffic done");
        do_reset();
        wr(1'b1, 5'h07, 8'h5a);
        chk_cfg();
        rd(1'b1, 5'h06);
        $display("test mid-run reset done");
        test_done();
    end
endmodule : wad_desc_store_bench
